// ==== src/dapm_regs.vh ====
// Constants for the dual converter power-mode control block
`ifndef DAPM_REGS_VH
`define DAPM_REGS_VH
// Power modes
`define DAPM_MODE_NORMAL    2'h0
`define DAPM_MODE_PARTIAL   2'h1
`define DAPM_MODE_FULL      2'h2
// Falling-edge thresholds within a frame
`define DAPM_EDGE_GLITCH    6'h02
`define DAPM_EDGE_KEEP      6'h0a
`define DAPM_EDGE_FRAME     6'h10
`define DAPM_EDGE_TRAIL     6'h12
`define DAPM_EDGE_DUAL      6'h20
// Result width and leading zeros
`define DAPM_RES_BITS       14
`define DAPM_LEAD_ZEROS     2
// Power-up times
`define DAPM_WAKE_NS        200
`define DAPM_DEEP_WAKE_NS   6000000
`define DAPM_CLK_MHZ        250
`define DAPM_WAKE_CYC       ((`DAPM_WAKE_NS * `DAPM_CLK_MHZ + 999) / 1000)
`define DAPM_DEEP_WAKE_CYC  ((`DAPM_DEEP_WAKE_NS * `DAPM_CLK_MHZ + 999) / 1000)
// Result FIFO
`define DAPM_FIFO_DEPTH     16
`endif

// ==== src/dapm_sync.v ====
// Two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module dapm_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire sys_clk_in,
  input  wire nrst_in,
  // Data
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;
  // Second flop alone reads the first
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // dapm_sync

// ==== src/dapm_fifo.v ====
// Flop-based FIFO holding result word pairs
`timescale 1ns/1ps
module dapm_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             nrst_in,
  // Fill side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // Drain side
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            do_wr;
  wire            do_rd;
  // Handshakes and flags
  assign wr_ready_out = (count_q != DEPTH[AW:0]);
  assign rd_valid_out = (count_q != {(AW+1){1'b0}});
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;
  assign rd_data_out  = mem_q[rd_ptr_q];
  // Storage
  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end
  // Pointers and fill count
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count_q <= count_q + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // dapm_fifo

// ==== src/dapm_top.v ====
// Power-mode control and serial output sequencing for a dual converter
// Notes on behaviour
// - Three modes chosen by select rise timing
// - Rise after 10th, before 16th: abort, powered
// - Sixteen clocks with select low per result
// - Outputs stay driven after sixteen until rise
// - Two trailing zeros after the result
// - Next sixteen carry other result, same line
// - Line released at 32nd fall or rise
// - Partial: all off except reference
// - Normal, rise edges 2..9: partial, abort
// - Rise before 2nd edge keeps mode
// - Partial wake: dummy past 10th, 200 ns
// - Partial, early rise: back to partial
// - Partial, rise edges 2..9: full down
// - Full: all analog off incl reference
// - Hold until first clock edge on wake
// - Select fall: hold, sample, start, drive
// - Two zeros then 14 bits MSB first
`timescale 1ns/1ps
`include "dapm_regs.vh"
module dapm_top #(
  parameter RES_BITS       = `DAPM_RES_BITS,
  parameter DEEP_WAKE_CYC  = `DAPM_DEEP_WAKE_CYC,
  parameter WAKE_CYC       = `DAPM_WAKE_CYC,
  parameter FIFO_DEPTH     = `DAPM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire                  sys_clk_in,
  input  wire                  nrst_in,
  // Host serial pins
  input  wire                  sel_n_in,
  input  wire                  sclk_in,
  output reg                   serial_out_first_out,
  output reg                   serial_out_first_oe_out,
  output reg                   serial_out_second_out,
  output reg                   serial_out_second_oe_out,
  // Converter result stream
  input  wire                  res_valid_in,
  output wire                  res_ready_out,
  input  wire [RES_BITS-1:0]   res_a_in,
  input  wire [RES_BITS-1:0]   res_b_in,
  // Analog power controls and status
  output reg                   analog_on_out,
  output reg                   ref_on_out,
  output reg                   track_out,
  output reg                   powered_out,
  output reg [1:0]             mode_out,
  output reg                   conv_start_out
);
  localparam W = 2 * RES_BITS;
  // Frame bit positions: lead zeros, first result, trailing zeros, other result
  localparam FIRST_LO  = `DAPM_LEAD_ZEROS;
  localparam FIRST_HI  = `DAPM_LEAD_ZEROS + RES_BITS - 1;
  localparam SECOND_LO = `DAPM_EDGE_FRAME + `DAPM_LEAD_ZEROS;
  localparam SECOND_HI = `DAPM_EDGE_FRAME + `DAPM_LEAD_ZEROS + RES_BITS - 1;

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  wire sel_n_s;
  wire sclk_s;
  reg  sel_n_q;
  reg  sclk_q;
  wire sel_fall;
  wire sel_rise;
  wire sclk_fall;
  wire sclk_rise;

  dapm_sync #(.RST_VAL(1'b1)) u_sync_sel (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .async_in   (sel_n_in),
    .sync_out   (sel_n_s)
  );

  dapm_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .async_in   (sclk_in),
    .sync_out   (sclk_s)
  );

  // Previous synchronised levels
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_n_q <= 1'b1;
      sclk_q  <= 1'b0;
    end else begin
      sel_n_q <= sel_n_s;
      sclk_q  <= sclk_s;
    end
  end

  assign sel_fall  = sel_n_q & ~sel_n_s;
  assign sel_rise  = ~sel_n_q & sel_n_s;
  assign sclk_fall = sclk_q & ~sclk_s & ~sel_n_s;
  assign sclk_rise = ~sclk_q & sclk_s & ~sel_n_s;

  // ----------------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------------
  wire         fifo_valid;
  wire [W-1:0] fifo_data;
  reg          fifo_pop;

  dapm_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (res_valid_in),
    .wr_ready_out (res_ready_out),
    .wr_data_in   ({res_a_in, res_b_in}),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Frame state: edge count, shift data, drive enable
  // ----------------------------------------------------------------
  reg [5:0]          edge_cnt_q;
  reg                in_frame_q;
  reg                drive_q;
  reg [RES_BITS-1:0] word_a_q;
  reg [RES_BITS-1:0] word_b_q;
  reg [1:0]          mode_q;
  reg                wake_pend_q;
  reg                deep_pend_q;
  reg [31:0]         wake_cnt_q;
  reg                powered_q;
  reg                track_q;
  reg                bit_a_d;
  reg                bit_b_d;
  integer            idx;

  // Bit presented after edge_cnt_q falling edges (lead zeros, result, trail)
  always @* begin
    bit_a_d = 1'b0;
    bit_b_d = 1'b0;
    idx     = 0;
    if (edge_cnt_q >= FIRST_LO && edge_cnt_q <= FIRST_HI) begin
      idx     = FIRST_HI - edge_cnt_q;
      bit_a_d = word_a_q[idx];
      bit_b_d = word_b_q[idx];
    end else if (edge_cnt_q >= SECOND_LO && edge_cnt_q <= SECOND_HI) begin
      idx     = SECOND_HI - edge_cnt_q;
      bit_a_d = word_b_q[idx];
      bit_b_d = word_a_q[idx];
    end
  end

  // Frame sequencing and mode decision
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      edge_cnt_q     <= 6'h00;
      in_frame_q     <= 1'b0;
      drive_q        <= 1'b0;
      word_a_q       <= {RES_BITS{1'b0}};
      word_b_q       <= {RES_BITS{1'b0}};
      mode_q         <= `DAPM_MODE_NORMAL;
      wake_pend_q    <= 1'b0;
      deep_pend_q    <= 1'b0;
      fifo_pop       <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      fifo_pop       <= 1'b0;
      conv_start_out <= 1'b0;
      if (sel_fall) begin
        // Sample, start conversion, leave three-state
        edge_cnt_q     <= 6'h00;
        in_frame_q     <= 1'b1;
        drive_q        <= 1'b1;
        conv_start_out <= 1'b1;
        if (fifo_valid) begin
          word_a_q <= fifo_data[W-1:RES_BITS];
          word_b_q <= fifo_data[RES_BITS-1:0];
          fifo_pop <= 1'b1;
        end
      end else if (sel_rise && in_frame_q) begin
        in_frame_q <= 1'b0;
        drive_q    <= 1'b0;
        if (edge_cnt_q < `DAPM_EDGE_GLITCH) begin
          // Glitch: mode unchanged, wake and deep-wake pending flags cleared
          wake_pend_q <= 1'b0;
          deep_pend_q <= 1'b0;
        end else if (edge_cnt_q < `DAPM_EDGE_KEEP) begin
          wake_pend_q <= 1'b0;
          deep_pend_q <= 1'b0;
          if (mode_q == `DAPM_MODE_NORMAL) begin
            mode_q <= `DAPM_MODE_PARTIAL;
          end else begin
            mode_q <= `DAPM_MODE_FULL;
          end
        end else if (mode_q != `DAPM_MODE_NORMAL) begin
          // Dummy conversion held past the tenth edge
          mode_q <= `DAPM_MODE_NORMAL;
        end
        // Rise after tenth edge in normal: stays powered, aborted
      end else if (in_frame_q && sclk_fall) begin
        if (edge_cnt_q != 6'h3f) begin
          edge_cnt_q <= edge_cnt_q + 6'h01;
        end
        if (edge_cnt_q + 6'h01 == `DAPM_EDGE_DUAL) begin
          drive_q <= 1'b0;
        end
        if (edge_cnt_q + 6'h01 == `DAPM_EDGE_KEEP && mode_q != `DAPM_MODE_NORMAL) begin
          wake_pend_q <= 1'b1;
          deep_pend_q <= (mode_q == `DAPM_MODE_FULL);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-up timer and track-and-hold
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_cnt_q <= 32'h00000000;
      powered_q  <= 1'b1;
      track_q    <= 1'b1;
    end else begin
      // Hold from select fall; track again per mode
      if (sel_fall) begin
        track_q <= 1'b0;
      end else if (in_frame_q && mode_q != `DAPM_MODE_NORMAL && (sclk_fall || sclk_rise)) begin
        track_q <= 1'b1;
      end else if (in_frame_q && sclk_rise && edge_cnt_q >= 6'h0f) begin
        track_q <= 1'b1;
      end else if (sel_rise) begin
        track_q <= 1'b1;
      end
      // Wake delay counted from select fall
      if (sel_fall && mode_q != `DAPM_MODE_NORMAL) begin
        wake_cnt_q <= 32'h00000000;
      end else if (mode_q != `DAPM_MODE_NORMAL) begin
        powered_q <= 1'b0;
        if (in_frame_q) begin
          wake_cnt_q <= wake_cnt_q + 32'h00000001;
        end
      end else if (wake_pend_q || !powered_q) begin
        if (wake_cnt_q >= (deep_pend_q ? DEEP_WAKE_CYC : WAKE_CYC)) begin
          powered_q <= 1'b1;
        end else begin
          wake_cnt_q <= wake_cnt_q + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_out_first_out     <= 1'b0;
      serial_out_first_oe_out  <= 1'b0;
      serial_out_second_out    <= 1'b0;
      serial_out_second_oe_out <= 1'b0;
      analog_on_out            <= 1'b1;
      ref_on_out               <= 1'b1;
      track_out                <= 1'b1;
      powered_out              <= 1'b1;
      mode_out                 <= `DAPM_MODE_NORMAL;
    end else begin
      // Frame bit on both lines, released on abort or after 32
      serial_out_first_out     <= bit_a_d;
      serial_out_second_out    <= bit_b_d;
      serial_out_first_oe_out  <= drive_q;
      serial_out_second_oe_out <= drive_q && (edge_cnt_q < `DAPM_EDGE_DUAL);
      // Analog power per mode, wake in frame after select fall
      analog_on_out <= (mode_q == `DAPM_MODE_NORMAL) || in_frame_q;
      ref_on_out    <= (mode_q != `DAPM_MODE_FULL) || in_frame_q;
      // Held in hold while powered down, outside a wake frame
      track_out     <= track_q && ((mode_q == `DAPM_MODE_NORMAL) || in_frame_q);
      powered_out   <= powered_q;
      mode_out      <= mode_q;
    end
  end
endmodule // dapm_top

// ==== verification/dapm_top_monitor.sv ====
// Port checker for the power-mode control block
`timescale 1ns/1ps
module dapm_monitor (
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       nrst_in,
  // Host select
  input wire logic       sel_n_in,
  // Serial lines
  input wire logic       serial_out_first_out,
  input wire logic       serial_out_first_oe_out,
  input wire logic       serial_out_second_out,
  input wire logic       serial_out_second_oe_out,
  // Power and status
  input wire logic       analog_on_out,
  input wire logic       ref_on_out,
  input wire logic       track_out,
  input wire logic       powered_out,
  input wire logic [1:0] mode_out,
  input wire logic       conv_start_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // -----------------------------
  // Frame start, line enable, power and mode rules
  // -----------------------------
  sequence s_lead_zero;
    ##[0:4] (serial_out_first_oe_out && !serial_out_first_out && !serial_out_second_out);
  endsequence
  property p_start_drive; conv_start_out |-> s_lead_zero; endproperty
  property p_start_pulse; conv_start_out |=> !conv_start_out; endproperty
  property p_start_sel; conv_start_out |-> !sel_n_in; endproperty
  property p_hold_on_drive; $rose(serial_out_first_oe_out) |-> !track_out; endproperty
  property p_oe_pair; serial_out_first_oe_out == serial_out_second_oe_out; endproperty
  property p_idle_release; sel_n_in [*6] |-> !serial_out_first_oe_out; endproperty
  property p_ref_first; analog_on_out |-> ref_on_out; endproperty
  property p_mode_legal; mode_out != 2'h3; endproperty
  property p_mode_quiet; $changed(mode_out) |-> !serial_out_first_oe_out; endproperty
  property p_wake_on; $rose(powered_out) |-> analog_on_out; endproperty
  // Assertions
  a_start_drive: assert property (p_start_drive)
    else $error("no driven leading zero after start");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  a_start_sel: assert property (p_start_sel)
    else $error("start without select low");
  a_hold_on_drive: assert property (p_hold_on_drive)
    else $error("tracking while lines driven");
  a_oe_pair: assert property (p_oe_pair)
    else $error("line enables differ");
  a_idle_release: assert property (p_idle_release)
    else $error("line driven with select high");
  a_ref_first: assert property (p_ref_first)
    else $error("analog on without reference");
  a_mode_legal: assert property (p_mode_legal)
    else $error("illegal mode");
  a_mode_quiet: assert property (p_mode_quiet)
    else $error("mode changed mid frame");
  a_wake_on: assert property (p_wake_on)
    else $error("powered without analog");
endmodule // dapm_monitor

bind dapm_top dapm_monitor u_dapm_monitor (.sys_clk_in, .nrst_in, .sel_n_in,
  .serial_out_first_out, .serial_out_first_oe_out, .serial_out_second_out,
  .serial_out_second_oe_out, .analog_on_out, .ref_on_out, .track_out,
  .powered_out, .mode_out, .conv_start_out);

// ==== verification/dapm_host.sv ====
// Host serial port model driving select and the serial clock
`timescale 1ns/1ps
module dapm_host (
  // Clock
  input  wire logic clk_in,
  // Device lines
  input  wire logic da_in,
  input  wire logic da_oe_in,
  input  wire logic db_in,
  input  wire logic db_oe_in,
  // Host pins
  output logic      sel_n_out,
  output logic      sclk_out
);
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic        oe_end;
  // Idle: select high, serial clock stands high
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b1;
  end
  // Half serial period, 80 ns
  task automatic half();
    repeat (20) @(negedge clk_in);
  endtask
  // Released lines read as pulled high
  task automatic grab(input int k);
    cap_a[31-k] = da_oe_in ? da_in : 1'b1;
    cap_b[31-k] = db_oe_in ? db_in : 1'b1;
  endtask
  // Frame of n falls, select raised after the last
  task automatic frame(input int n);
    cap_a = '0;
    cap_b = '0;
    sel_n_out = 1'b0;
    half();
    grab(0);
    for (int k = 1; k <= n; k++) begin
      sclk_out = 1'b0;
      half();
      sclk_out = 1'b1;
      if (k < 32) grab(k);
      half();
    end
    oe_end = da_oe_in;
    sel_n_out = 1'b1;
    half();
    half();
  endtask
endmodule // dapm_host

// ==== verification/test_dual_adc_power_mode_control.sv ====
// Self-checking bench for the power-mode control block
`timescale 1ns/1ps
`include "dapm_regs.vh"
module test_dual_adc_power_mode_control;
  typedef struct packed {
    logic [5:0] n;
    logic [1:0] md;
    logic       rf;
    logic       an;
  } dapm_row_t;
  localparam logic [13:0] RA = 14'h2a5c;
  localparam logic [13:0] RB = 14'h13c7;
  localparam logic [1:0]  MN = `DAPM_MODE_NORMAL;
  localparam logic [1:0]  MP = `DAPM_MODE_PARTIAL;
  localparam logic [1:0]  MF = `DAPM_MODE_FULL;
  logic       sys_clk_in, nrst_in, res_valid_in, res_ready_out;
  logic       analog_on, ref_on, track, powered, conv_start;
  logic [1:0] mode;
  wire        sel_n, sclk, da, da_oe, db, db_oe;
  int         err_total, checks, cyc;
  dapm_row_t  rows [10];
  // Device under test
  dapm_top #(.DEEP_WAKE_CYC(100), .WAKE_CYC(50)) u_dapm_top (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .sel_n_in(sel_n), .sclk_in(sclk),
    .serial_out_first_out(da), .serial_out_first_oe_out(da_oe),
    .serial_out_second_out(db), .serial_out_second_oe_out(db_oe),
    .res_valid_in(res_valid_in), .res_ready_out(res_ready_out),
    .res_a_in(RA), .res_b_in(RB), .analog_on_out(analog_on), .ref_on_out(ref_on),
    .track_out(track), .powered_out(powered), .mode_out(mode),
    .conv_start_out(conv_start));
  // Host model
  dapm_host u_dapm_host (.clk_in(sys_clk_in), .da_in(da), .da_oe_in(da_oe),
    .db_in(db), .db_oe_in(db_oe), .sel_n_out(sel_n), .sclk_out(sclk));
  // Clock, 4 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Verdict
  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end
  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    nrst_in = 1'b0;
    res_valid_in = 1'b0;
    rows[0] = '{6'd1, MN, 1'b1, 1'b1};
    rows[1] = '{6'd5, MP, 1'b1, 1'b0};
    rows[2] = '{6'd1, MP, 1'b1, 1'b0};
    rows[3] = '{6'd5, MF, 1'b0, 1'b0};
    rows[4] = '{6'd12, MN, 1'b1, 1'b1};
    rows[5] = '{6'd12, MN, 1'b1, 1'b1};
    rows[6] = '{6'd5, MP, 1'b1, 1'b0};
    rows[7] = '{6'd12, MN, 1'b1, 1'b1};
    rows[8] = '{6'd16, MN, 1'b1, 1'b1};
    rows[9] = '{6'd32, MN, 1'b1, 1'b1};
    repeat (20) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    chk({mode, ref_on, analog_on, track, powered, da_oe, db_oe}, 8'h3c);
    repeat (3) @(negedge sys_clk_in);
    // Fill the result buffer until it refuses
    res_valid_in = 1'b1;
    repeat (16) begin
      chk(res_ready_out, 1'b1);
      @(negedge sys_clk_in);
    end
    res_valid_in = 1'b0;
    chk(res_ready_out, 1'b0);
    foreach (rows[i]) begin
      u_dapm_host.frame(rows[i].n);
      chk({mode, ref_on, analog_on, track, powered},
          {rows[i].md, rows[i].rf, {3{rows[i].an}}});
      if (rows[i].n >= 16) begin
        chk(u_dapm_host.cap_a[31:16], {2'b0, RA});
        chk(u_dapm_host.cap_b[31:16], {2'b0, RB});
        chk(u_dapm_host.oe_end, rows[i].n == 16);
      end
      if (rows[i].n == 32) begin
        chk(u_dapm_host.cap_a[15:0], {2'b0, RB});
        chk(u_dapm_host.cap_b[15:0], {2'b0, RA});
      end
    end
    chk(res_ready_out, 1'b1);
    // Reset while powered down returns to normal
    u_dapm_host.frame(5);
    nrst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk({mode, ref_on, analog_on, da_oe}, 5'h06);
    nrst_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    // Dummy cycles after start-up: aborted after 12 falls, then partial entry
    u_dapm_host.frame(12);
    chk({mode, ref_on, analog_on, track, powered}, {MN, 4'hf});
    u_dapm_host.frame(5);
    chk({mode, ref_on, analog_on, track, powered}, {MP, 4'h8});
    conclude();
  end
endmodule // test_dual_adc_power_mode_control
